// ---- design/tick_pkg.sv ----
package tick_pkg;

    localparam int ADDR_W   = 4;
    localparam int DATA_W   = 8;
    localparam int COUNT_W  = 8;
    localparam int PERIOD_W = 3;
    localparam int EVENT_W  = 2;

    localparam logic [ADDR_W-1:0] CTRL_OFFSET       = 4'h0;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_OFFSET = 4'h1;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFFSET   = 4'h2;
    localparam logic [ADDR_W-1:0] COUNT_OFFSET      = 4'h3;

    localparam int FLAG_BIT   = 7;
    localparam int ACK_BIT    = 6;
    localparam int CLKSEL_BIT = 5;
    localparam int ENABLE_BIT = 4;
    localparam int UNUSED_BIT = 3;
    localparam int PERIOD_LSB = 0;

    localparam int EVENT_TICK        = 0;
    localparam int EVENT_FAST_MISUSE = 1;

    localparam logic [PERIOD_W-1:0] PERIOD_OFF   = 3'h0;
    localparam logic [PERIOD_W-1:0] PERIOD_RESET = 3'h0;
    localparam logic                FLAG_RESET   = 1'b0;
    localparam logic                ENABLE_RESET = 1'b0;
    localparam logic [EVENT_W-1:0]  MASK_RESET   = 2'h0;

    localparam logic [COUNT_W-1:0] COUNT_ZERO = 8'h00;
    localparam logic [COUNT_W-1:0] COUNT_ONE  = 8'h01;
    localparam logic [DATA_W-1:0]  DATA_ZERO  = 8'h00;

    typedef enum logic {
        SRC_SLOW = 1'b0,
        SRC_FAST = 1'b1
    } clock_source_type;

    localparam clock_source_type CLKSEL_RESET = SRC_SLOW;

    // Last count value of a period of 2^sel ticks
    function automatic logic [COUNT_W-1:0] period_terminal(input logic [PERIOD_W-1:0] sel);
        period_terminal = (COUNT_ONE << sel) - COUNT_ONE;
    endfunction

endpackage

// ---- design/periodic_tick_timer.sv ----
`timescale 1ns/1ps
module periodic_tick_timer (
    input  wire logic                       clk,
    input  wire logic                       nrst,
    input  wire logic [tick_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [tick_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                       reg_write,
    input  wire logic                       reg_read,
    output logic      [tick_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic                       slow_osc_tick,
    input  wire logic                       fast_osc_tick,
    input  wire logic                       run_mode,
    output logic                            slow_osc_enable,
    output logic                            tick_irq,
    output logic                            wakeup,
    output logic                            irq
);
    import tick_pkg::*;

    typedef struct packed {
        logic                      flag;
        clock_source_type          clock_sel;
        logic                      enable;
        logic [PERIOD_W-1:0]       period;
        logic [COUNT_W-1:0]        count;
        logic [EVENT_W-1:0]        status;
        logic [EVENT_W-1:0]        mask;
        logic                      misuse_prev;
        logic                      wakeup;
        logic [DATA_W-1:0]         rdata;
    } state_type;

    localparam state_type STATE_RESET = '{
        flag:        FLAG_RESET,
        clock_sel:   CLKSEL_RESET,
        enable:      ENABLE_RESET,
        period:      PERIOD_RESET,
        count:       COUNT_ZERO,
        status:      '0,
        mask:        MASK_RESET,
        misuse_prev: 1'b0,
        wakeup:      1'b0,
        rdata:       DATA_ZERO
    };

    state_type             s_q;
    state_type             s_d;
    logic                  sel_tick;
    logic                  running;
    logic                  elapse;
    logic                  ctrl_write;
    logic                  ack_clear;
    logic                  misuse;
    logic [EVENT_W-1:0]    events;
    logic [DATA_W-1:0]     ctrl_view;
    logic                  retime;
    logic [PERIOD_W-1:0]   wr_period;
    logic                  wr_clksel;
    logic                  wr_enable;
    logic [EVENT_W-1:0]    wr_mask;

    // Oscillator has no power-down path at all
    assign slow_osc_enable = 1'b1;

    always_comb begin
        // Fast ticks vanish outside run mode; count simply stalls there
        if (s_q.clock_sel == SRC_FAST) begin
            sel_tick = fast_osc_tick & run_mode;
        end else begin
            sel_tick = slow_osc_tick;
        end
    end

    assign running    = (s_q.period != PERIOD_OFF);
    assign elapse     = running & sel_tick & (s_q.count == period_terminal(s_q.period));
    assign ctrl_write = reg_write & (reg_addr == CTRL_OFFSET);
    assign ack_clear  = ctrl_write & reg_wdata[ACK_BIT];
    assign misuse     = (s_q.clock_sel == SRC_FAST) & ~run_mode;
    assign events     = {misuse & ~s_q.misuse_prev, elapse};
    assign wr_period  = reg_wdata[PERIOD_LSB +: PERIOD_W];
    assign wr_clksel  = reg_wdata[CLKSEL_BIT];
    assign wr_enable  = reg_wdata[ENABLE_BIT];
    assign wr_mask    = reg_wdata[EVENT_W-1:0];
    // Rewriting the same timing must not cut the running period short
    assign retime     = ctrl_write &
                        ((wr_period != s_q.period) | (wr_clksel != s_q.clock_sel));

    always_comb begin
        ctrl_view                          = DATA_ZERO;
        ctrl_view[FLAG_BIT]                = s_q.flag;
        ctrl_view[CLKSEL_BIT]              = s_q.clock_sel;
        ctrl_view[ENABLE_BIT]              = s_q.enable;
        ctrl_view[PERIOD_LSB +: PERIOD_W]  = s_q.period;
        // Ack and unused bits stay at zero in the view
    end

    always_comb begin
        s_d             = s_q;
        s_d.rdata       = DATA_ZERO;
        s_d.misuse_prev = misuse;

        if (!running) begin
            s_d.count = COUNT_ZERO;
        end else if (sel_tick) begin
            if (elapse) begin
                s_d.count = COUNT_ZERO;
            end else begin
                s_d.count = s_q.count + COUNT_ONE;
            end
        end

        // Set beats ack in the same cycle so no period is lost
        s_d.flag = (s_q.flag & ~ack_clear) | elapse;

        if (ctrl_write) begin
            s_d.clock_sel = clock_source_type'(reg_wdata[CLKSEL_BIT]);
            s_d.enable    = reg_wdata[ENABLE_BIT];
            s_d.period    = reg_wdata[PERIOD_LSB +: PERIOD_W];
            // Changing timing restarts the period from zero
            if (retime) begin
                s_d.count = COUNT_ZERO;
            end
        end

        if (reg_write && reg_addr == IRQ_MASK_OFFSET) begin
            s_d.mask = reg_wdata[EVENT_W-1:0];
        end

        if (reg_read && reg_addr == IRQ_STATUS_OFFSET) begin
            s_d.status = events;
        end else begin
            s_d.status = s_q.status | events;
        end

        // Wakeup only matters while the processor sleeps
        s_d.wakeup = elapse & s_q.enable & ~run_mode;

        if (reg_read) begin
            case (reg_addr)
                CTRL_OFFSET: begin
                    s_d.rdata = ctrl_view;
                end
                IRQ_STATUS_OFFSET: begin
                    s_d.rdata = {{(DATA_W-EVENT_W){1'b0}}, s_q.status};
                end
                IRQ_MASK_OFFSET: begin
                    s_d.rdata = {{(DATA_W-EVENT_W){1'b0}}, s_q.mask};
                end
                COUNT_OFFSET: begin
                    s_d.rdata = s_q.count;
                end
                default: begin
                    s_d.rdata = DATA_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign wakeup    = s_q.wakeup;
    // Periodic interrupt toward the processor, level until acked or enable is cleared
    assign tick_irq  = s_q.flag & s_q.enable;
    assign irq       = |(s_q.status & s_q.mask);

    // Independent tick tally for checking period length
    logic [COUNT_W-1:0] hlp_ticks;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hlp_ticks <= COUNT_ZERO;
        end else if (!running || elapse || retime) begin
            hlp_ticks <= COUNT_ZERO;
        end else if (sel_tick) begin
            hlp_ticks <= hlp_ticks + COUNT_ONE;
        end
    end

    wakeup_pulse_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (elapse && s_q.enable && !run_mode) |=> wakeup ##1 !wakeup
    ) else $error("Wakeup pulse missing after elapsed period");

    wakeup_run_a: assert property (
        @(posedge clk) disable iff (!nrst)
        wakeup |-> !$past(run_mode) && $past(elapse) && $past(s_q.enable)
    ) else $error("Wakeup without elapse in low power");

    slow_osc_on_a: assert property (
        @(posedge clk) disable iff (!nrst)
        slow_osc_enable
    ) else $error("Slow oscillator enable dropped");

    flag_set_a: assert property (
        @(posedge clk) disable iff (!nrst)
        elapse |=> s_q.flag
    ) else $error("Tick flag not set on elapsed period");

    ack_clear_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (ack_clear && !elapse) |=> !s_q.flag
    ) else $error("Ack write did not clear tick flag");

    flag_hold_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (s_q.flag && !ack_clear) |=> s_q.flag
    ) else $error("Tick flag cleared without ack");

    ack_zero_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (reg_read && reg_addr == CTRL_OFFSET) |=> !reg_rdata[ACK_BIT]
    ) else $error("Ack bit read back nonzero");

    clock_select_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (running && !ctrl_write && !sel_tick) |=> $stable(s_q.count)
    ) else $error("Count moved without selected tick");

    fast_gate_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (running && !ctrl_write && s_q.clock_sel == SRC_FAST && !run_mode)
        |=> $stable(s_q.count)
    ) else $error("Fast clock counted outside run mode");

    irq_gate_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (!s_q.enable |-> !tick_irq) and (s_q.flag && s_q.enable |-> tick_irq)
    ) else $error("Tick interrupt not gated by enable");

    wakeup_gate_a: assert property (
        @(posedge clk) disable iff (!nrst)
        !s_q.enable |=> !wakeup
    ) else $error("Wakeup passed while disabled");

    period_len_a: assert property (
        @(posedge clk) disable iff (!nrst)
        elapse |-> hlp_ticks == period_terminal(s_q.period)
    ) else $error("Period length differs from selected field");

    period_off_a: assert property (
        @(posedge clk) disable iff (!nrst)
        !running |-> !elapse && s_q.count == COUNT_ZERO
    ) else $error("Timer active while period field is off");

    reset_clear_a: assert property (
        @(posedge clk)
        !nrst |=> !s_q.flag && !s_q.enable && s_q.period == PERIOD_OFF
    ) else $error("Reset left control bits set");

    restart_a: assert property (
        @(posedge clk) disable iff (!nrst)
        elapse |=> s_q.count == COUNT_ZERO
    ) else $error("Count did not restart after period");

    unused_bit_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (reg_read && reg_addr == CTRL_OFFSET) |=> !reg_rdata[UNUSED_BIT]
    ) else $error("Unused control bit read back nonzero");

    status_sticky_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (elapse && reg_read && reg_addr == IRQ_STATUS_OFFSET)
        |=> s_q.status[EVENT_TICK]
    ) else $error("Tick event lost under status read");

    misuse_event_a: assert property (
        @(posedge clk) disable iff (!nrst)
        $rose(misuse) |=> s_q.status[EVENT_FAST_MISUSE]
    ) else $error("Fast clock misuse not recorded");

    retime_restart_a: assert property (
        @(posedge clk) disable iff (!nrst)
        retime |=> s_q.count == COUNT_ZERO
    ) else $error("Count kept after timing change");

    count_step_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (running && sel_tick && !elapse && !ctrl_write)
        |=> s_q.count == $past(s_q.count) + COUNT_ONE
    ) else $error("Count did not advance on selected tick");

    slow_only_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (s_q.clock_sel == SRC_SLOW && !slow_osc_tick && !ctrl_write)
        |=> $stable(s_q.count)
    ) else $error("Count moved without slow tick");

    flag_cause_a: assert property (
        @(posedge clk) disable iff (!nrst)
        $rose(s_q.flag) |-> $past(elapse)
    ) else $error("Tick flag set without elapsed period");

    flag_read_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (reg_read && reg_addr == CTRL_OFFSET) |=> reg_rdata[FLAG_BIT] == $past(s_q.flag)
    ) else $error("Tick flag read back wrong");

    clksel_write_a: assert property (
        @(posedge clk) disable iff (!nrst)
        ctrl_write |=> s_q.clock_sel == $past(wr_clksel)
    ) else $error("Clock select not taken from write");

    enable_write_a: assert property (
        @(posedge clk) disable iff (!nrst)
        ctrl_write |=> s_q.enable == $past(wr_enable)
    ) else $error("Interrupt enable not taken from write");

    period_write_a: assert property (
        @(posedge clk) disable iff (!nrst)
        ctrl_write |=> s_q.period == $past(wr_period)
    ) else $error("Period field not taken from write");

    period_read_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (reg_read && reg_addr == CTRL_OFFSET)
        |=> reg_rdata[PERIOD_LSB +: PERIOD_W] == $past(s_q.period)
    ) else $error("Period field read back wrong");

    mask_write_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (reg_write && reg_addr == IRQ_MASK_OFFSET) |=> s_q.mask == $past(wr_mask)
    ) else $error("Interrupt mask not taken from write");

    status_read_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (reg_read && reg_addr == IRQ_STATUS_OFFSET)
        |=> reg_rdata[EVENT_W-1:0] == $past(s_q.status)
    ) else $error("Status read back wrong");

    status_clear_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (reg_read && reg_addr == IRQ_STATUS_OFFSET && events == '0) |=> s_q.status == '0
    ) else $error("Status not cleared by read");

    status_set_a: assert property (
        @(posedge clk) disable iff (!nrst)
        elapse |=> s_q.status[EVENT_TICK]
    ) else $error("Tick event not recorded in status");

    rdata_idle_a: assert property (
        @(posedge clk) disable iff (!nrst)
        !reg_read |=> reg_rdata == DATA_ZERO
    ) else $error("Read data stood without a read");

    count_read_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (reg_read && reg_addr == COUNT_OFFSET) |=> reg_rdata == $past(s_q.count)
    ) else $error("Count read back wrong");

endmodule

// ---- tb/periodic_tick_timer_tb.sv ----
`timescale 1ns/1ps
module periodic_tick_timer_tb;
    import tick_pkg::*;

    logic              clk;
    logic              nrst;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic              reg_write;
    logic              reg_read;
    logic [DATA_W-1:0] reg_rdata;
    logic              slow_osc_tick;
    logic              fast_osc_tick;
    logic              run_mode;
    logic              slow_osc_enable;
    logic              tick_irq;
    logic              wakeup;
    logic              irq;
    int                error_cnt;
    int                total_checks;
    int                wake_cnt;
    int                cycle_cnt;

    periodic_tick_timer dut (
        .clk             (clk),
        .nrst            (nrst),
        .reg_addr        (reg_addr),
        .reg_wdata       (reg_wdata),
        .reg_write       (reg_write),
        .reg_read        (reg_read),
        .reg_rdata       (reg_rdata),
        .slow_osc_tick   (slow_osc_tick),
        .fast_osc_tick   (fast_osc_tick),
        .run_mode        (run_mode),
        .slow_osc_enable (slow_osc_enable),
        .tick_irq        (tick_irq),
        .wakeup          (wakeup),
        .irq             (irq)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Wakeup is a one-cycle pulse, so count every edge it is seen on
    always @(posedge clk) begin
        cycle_cnt++;
        if (wakeup === 1'b1) begin
            wake_cnt++;
        end
        if (cycle_cnt == 20000) begin
            error_cnt++;
            $display("Error at %0t: run did not finish", $time);
            give_verdict();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string what);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata, exp, what);
    endtask

    // Ticks two cycles apart so the strobe is never reassigned in one step
    task automatic tick(input logic fast, input int n);
        repeat (n) begin
            @(posedge clk);
            if (fast) fast_osc_tick <= 1'b1;
            else slow_osc_tick <= 1'b1;
            @(posedge clk);
            fast_osc_tick <= 1'b0;
            slow_osc_tick <= 1'b0;
        end
    endtask

    task automatic settle();
        @(posedge clk);
        #1;
    endtask

    task automatic t_reset_state();
        tick(1'b0, 2);
        rd(CTRL_OFFSET, 8'h00, "ctrl reset");
        rd(IRQ_STATUS_OFFSET, 8'h00, "status reset");
        rd(IRQ_MASK_OFFSET, 8'h00, "mask reset");
        rd(COUNT_OFFSET, 8'h00, "count reset");
        chk(slow_osc_enable, 8'h01, "slow osc on");
        wr(4'hf, 8'hff);
        rd(4'hf, 8'h00, "unmapped read");
        rd(CTRL_OFFSET, 8'h00, "unmapped write");
        $display("done: reset state");
    endtask

    task automatic t_periods();
        @(posedge clk);
        run_mode <= 1'b1;
        for (int n = 1; n < 8; n++) begin
            wr(CTRL_OFFSET, 8'h10 | 8'(n));
            tick(1'b0, (1 << n) - 1);
            rd(CTRL_OFFSET, 8'h10 | 8'(n), "early flag");
            tick(1'b0, 1);
            settle();
            chk(tick_irq, 8'h01, "tick irq");
            rd(CTRL_OFFSET, 8'h90 | 8'(n), "period flag");
            rd(COUNT_OFFSET, 8'h00, "count restart");
            wr(CTRL_OFFSET, 8'h50 | 8'(n));
            rd(CTRL_OFFSET, 8'h10 | 8'(n), "ack");
        end
        chk(irq, 8'h00, "masked irq");
        wr(IRQ_MASK_OFFSET, 8'h01);
        rd(IRQ_MASK_OFFSET, 8'h01, "mask readback");
        settle();
        chk(irq, 8'h01, "unmasked irq");
        rd(IRQ_STATUS_OFFSET, 8'h01, "status set");
        settle();
        chk(irq, 8'h00, "irq after read");
        rd(IRQ_STATUS_OFFSET, 8'h00, "status cleared");
        $display("done: periods");
    endtask

    task automatic t_flag_writes();
        wr(CTRL_OFFSET, 8'h11);
        tick(1'b0, 2);
        wr(CTRL_OFFSET, 8'h11);
        wr(CTRL_OFFSET, 8'h19);
        rd(CTRL_OFFSET, 8'h91, "flag kept");
        wr(CTRL_OFFSET, 8'h51);
        rd(CTRL_OFFSET, 8'h11, "ack reads 0");
        rd(IRQ_STATUS_OFFSET, 8'h01, "status");
        $display("done: flag writes");
    endtask

    task automatic t_wakeup();
        @(posedge clk);
        run_mode <= 1'b0;
        wake_cnt = 0;
        wr(CTRL_OFFSET, 8'h11);
        tick(1'b0, 2);
        rd(CTRL_OFFSET, 8'h91, "low power flag");
        chk(8'(wake_cnt), 8'h01, "one wakeup");
        wr(CTRL_OFFSET, 8'h51);
        wr(CTRL_OFFSET, 8'h01);
        tick(1'b0, 2);
        settle();
        chk(tick_irq, 8'h00, "irq disabled");
        rd(CTRL_OFFSET, 8'h81, "flag without enable");
        chk(8'(wake_cnt), 8'h01, "no wakeup");
        wr(CTRL_OFFSET, 8'h41);
        rd(IRQ_STATUS_OFFSET, 8'h01, "status");
        $display("done: wakeup");
    endtask

    task automatic t_fast_clock();
        @(posedge clk);
        run_mode <= 1'b1;
        wr(CTRL_OFFSET, 8'h31);
        tick(1'b0, 2);
        rd(CTRL_OFFSET, 8'h31, "slow ignored");
        tick(1'b1, 2);
        rd(CTRL_OFFSET, 8'hb1, "fast period");
        wr(CTRL_OFFSET, 8'h71);
        rd(IRQ_STATUS_OFFSET, 8'h01, "status");
        @(posedge clk);
        run_mode <= 1'b0;
        tick(1'b1, 2);
        rd(IRQ_STATUS_OFFSET, 8'h02, "fast misuse");
        rd(CTRL_OFFSET, 8'h31, "fast gated");
        $display("done: fast clock");
    endtask

    task automatic t_mid_reset();
        @(posedge clk);
        run_mode <= 1'b1;
        wr(CTRL_OFFSET, 8'h13);
        tick(1'b0, 1);
        rd(COUNT_OFFSET, 8'h01, "count");
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        t_reset_state();
        $display("done: mid reset");
    endtask

    initial begin
        nrst = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        slow_osc_tick = 1'b0;
        fast_osc_tick = 1'b0;
        run_mode = 1'b0;
        error_cnt = 0;
        total_checks = 0;
        wake_cnt = 0;
        cycle_cnt = 0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        t_reset_state();
        t_periods();
        t_flag_writes();
        t_wakeup();
        t_fast_clock();
        t_mid_reset();
        give_verdict();
    end
endmodule
